// file: hw/mbh_pkg.sv
// Constants, register map and state encodings of the host control block.
package mbh_pkg;

	localparam int CLK_PERIOD_NS = 25;
	localparam int WAIT_NS       = 75;
	localparam int CAPT_NS       = 50;
	localparam int BUS_BACKOFF_OUT_NS       = 100;
	localparam int STROBE_NS     = 100;
	localparam int DRAIN_NS      = 200;
	// Least times, so each count rounds up to whole cycles.
	localparam int WAIT_CYC   = (WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAPT_CYC   = (CAPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUS_BACKOFF_OUT_CYC   = (BUS_BACKOFF_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int DRAIN_CYC  = (DRAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [3:0] REG_ROM_CTL = 4'h0;
	localparam logic [3:0] REG_ZW_CTL  = 4'h1;
	localparam logic [3:0] REG_RETRACE = 4'h2;
	localparam logic [3:0] REG_STATUS  = 4'h3;

	localparam int ROM_EN_BIT  = 0;
	localparam int EXT_DAC_BIT = 1;
	localparam int MONO_BIT    = 2;
	localparam int ROM_SEL_BIT = 16;
	localparam int ZW_RD_BIT   = 6;
	localparam int ZW_WR_BIT   = 7;
	localparam int IRQ_CLR_BIT = 4;
	localparam int IRQ_EN_BIT  = 5;

	localparam logic [31:0] ROM_CTL_MASK = 32'h0001_0007;
	localparam logic [31:0] ROM_CTL_RST  = 32'h0000_0000;
	localparam logic [7:0]  ZW_RST       = 8'h00;
	localparam logic [7:0]  RETRACE_RST  = 8'h00;

	localparam logic [6:0]  VGA_MEM_HI  = 7'h05;
	localparam logic [6:0]  ROM_WIDE_HI = 7'h06;
	localparam logic [8:0]  ROM_EN_HI   = 9'h018;
	localparam logic [15:0] IO_PAGE_MAP = 16'h46e8;
	localparam logic [11:0] IO_LO_PAGE  = 12'h03b;
	localparam logic [11:0] IO_HI_PAGE  = 12'h03d;
	localparam logic [15:0] PAL_LO      = 16'h03c6;
	localparam logic [15:0] PAL_HI      = 16'h03c9;

	typedef enum logic [1:0] {
		MODE_LOCAL = 2'h0,
		MODE_AT    = 2'h1,
		MODE_CHAN  = 2'h2
	} mbh_mode_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_WAIT  = 6'h02,
		ST_READY = 6'h04,
		ST_BUS_BACKOFF_OUT  = 6'h08,
		ST_BUSY  = 6'h10,
		ST_DONE  = 6'h20
	} mbh_state_t;

endpackage : mbh_pkg

// file: hw/mbh_sync.sv
// Three-stage pin synchroniser with agreement filter, one per bit.
`timescale 1ns/10ps
module mbh_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				s1_q[i] <= 1'b0;
				s2_q[i] <= 1'b0;
				s3_q[i] <= 1'b0;
				dout[i] <= 1'b0;
			end else if (ce) begin
				s1_q[i] <= din[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				// A change is taken only once two late stages agree.
				if (s2_q[i] == s3_q[i]) begin
					dout[i] <= s3_q[i];
				end
			end
		end
	end

endmodule : mbh_sync

// file: hw/mbh_host_ctl.sv
// Host bus control signalling for local, AT-style and channel buses.
//
// Operation
// - Local mode: drive backoff low when a write meets full write buffers.
// - AT mode: ROM select decodes latched upper address for 0C0000h-0DFFFFh.
// - Decode-disable strap set: ROM select mirrors ROM control bit 16.
// - Forwarded palette or mono writes hold local busy until data captured.
// - AT/channel: zero-wait output follows zero-wait control bits 7 and 6.
// - Local ready is active low, driven only when active, else released.
// - AT/channel: channel ready low while access incomplete, then high.
// - Feedback strap 0: local cycle ends once own ready is active.
// - Feedback strap 1: local cycle ends only when ready-input arrives.
// - AT mode: 16-bit I/O select low for claimed I/O accesses.
// - ROM enable low for C0000h-C7FFFh only when ROM control bit 0 set.
// - I/O write to 46E8h pulses ROM enable as a page-map strobe.
// - Interrupt requests arise only when retrace end bit 5 is set.
// - End of display sets interrupt; held until bit 4 clear is written.
// - Channel mode: same interrupt, signalled active low.
// - Shared pins take the function of the bus mode in use.
// - Processor reset aligns the internal phase to the double-rate clock.
// - AT/channel: memory decoded only while memory enable input is high.
// - AT mode: upper address latched on falling edge of latch enable.
// - Local/channel: memory-or-I/O low means I/O cycle, high means memory cycle.
// - Local mode: write-or-read low means read, high means write.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module mbh_host_ctl
	import mbh_pkg::*;
#(
	parameter int WBUF_DEPTH = 4
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [1:0]  mode_strap,
	input  wire logic        rom_decode_disable_strap,
	input  wire logic        ready_feedback_strap,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        vert_display_end,
	input  wire logic [23:0] host_addr,
	input  wire logic        link_clk,
	input  wire logic        cmd_strobe,
	input  wire logic        reset_or_mem_en,
	input  wire logic        final_ready_in,
	input  wire logic        addr_strobe,
	input  wire logic        card_select_feedback,
	input  wire logic        rw_strobe,
	input  wire logic        mio_strobe,
	input  wire logic        dc_strobe,
	output logic             backoff_romsel_o,
	output logic             backoff_romsel_oe,
	output logic             local_ready_out_o,
	output logic             local_ready_out_oe,
	output logic             busy_zero_wait_o,
	output logic             io_sel16_o,
	output logic             io_sel16_oe,
	output logic             bios_rom_enable_out_n,
	output logic             irq_o
);
	localparam int WBW = $clog2(WBUF_DEPTH + 1);

	logic [32:0] raw;
	logic [32:0] syn;
	logic [23:0] s_addr;
	logic        s_lclk, s_cmd, s_prst, s_final_ready_in, s_ads, s_card_select_feedback;
	logic        s_rw, s_mio, s_dc;

	mbh_sync #(.W(33)) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.din     (raw),
		.dout    (syn)
	);

	assign raw = {host_addr, link_clk, cmd_strobe, reset_or_mem_en,
		final_ready_in, addr_strobe, card_select_feedback, rw_strobe,
		mio_strobe, dc_strobe};
	assign {s_addr, s_lclk, s_cmd, s_prst, s_final_ready_in, s_ads, s_card_select_feedback, s_rw,
		s_mio, s_dc} = syn;

	mbh_mode_t   mode_q;
	logic        rom_dis_q, fb_q;
	mbh_state_t  st_q, st_d;
	logic [3:0]  cnt_q, stb_q, drain_q;
	logic [WBW-1:0] wb_q;
	logic [6:0]  la_q;
	logic        ale_prev_q, strb_prev_q, lclk_prev_q, phase_q;
	logic        cyc_mem_q, cyc_zw_q, pend_q;
	logic [31:0] rom_ctl_q;
	logic [7:0]  zw_q, retr_q;
	logic        lo_mode, at_mode, ch_mode, mem_en, strb, start;
	logic        is_mem, is_wr, claim, fwd, wb_full, zw_hit;
	logic        mem_now, zw_now, rom_win, page_wr, irq_clr;
	logic [23:0] cur_addr;

	// Straps are static, so they are simply caught while reset is held.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_q    <= mbh_mode_t'(mode_strap);
			rom_dis_q <= rom_decode_disable_strap;
			fb_q      <= ready_feedback_strap;
		end
	end

	always_comb begin
		at_mode  = (mode_q == MODE_AT);
		ch_mode  = (mode_q == MODE_CHAN);
		lo_mode  = !at_mode && !ch_mode;
		mem_en   = lo_mode || s_prst;
		cur_addr = at_mode ? {la_q, s_addr[16:0]} : s_addr;
		if (lo_mode) begin
			strb   = !s_ads;
			is_mem = s_mio;
			is_wr  = s_rw;
		end else if (at_mode) begin
			strb   = !s_mio || !s_dc || !s_rw || !s_cmd;
			is_mem = !s_mio || !s_dc;
			is_wr  = !s_dc || !s_cmd;
		end else begin
			// Slot setup is the host's job; no cycle is taken meanwhile.
			strb   = !s_cmd && s_final_ready_in;
			is_mem = s_mio;
			is_wr  = !s_dc;
		end
		start   = strb && !strb_prev_q;
		claim   = is_mem ? (mem_en && cur_addr[23:17] == VGA_MEM_HI)
			: (cur_addr[15:4] >= IO_LO_PAGE && cur_addr[15:4] <= IO_HI_PAGE);
		fwd     = lo_mode && !is_mem && is_wr
			&& ((rom_ctl_q[EXT_DAC_BIT] && cur_addr[15:0] >= PAL_LO
			&& cur_addr[15:0] <= PAL_HI)
			|| (rom_ctl_q[MONO_BIT] && cur_addr[15:4] == IO_LO_PAGE));
		wb_full = (wb_q == WBW'(WBUF_DEPTH));
		zw_hit  = is_mem && (is_wr ? zw_q[ZW_WR_BIT] : zw_q[ZW_RD_BIT]);
		mem_now = (st_q == ST_IDLE) ? is_mem : cyc_mem_q;
		zw_now  = (st_q == ST_IDLE) ? zw_hit : cyc_zw_q;
		rom_win = rom_ctl_q[ROM_EN_BIT] && mem_en && strb && is_mem
			&& !is_wr && cur_addr[23:15] == ROM_EN_HI;
		page_wr = start && !is_mem && is_wr
			&& cur_addr[15:0] == IO_PAGE_MAP;
		irq_clr = reg_wr && reg_addr == REG_RETRACE
			&& !reg_wdata[IRQ_CLR_BIT];
	end

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (start && fwd) begin
					st_d = ST_BUSY;
				end else if (start && claim) begin
					if (lo_mode && is_mem && is_wr && wb_full) begin
						st_d = ST_BUS_BACKOFF_OUT;
					end else if (!lo_mode && zw_hit) begin
						st_d = ST_DONE;
					end else begin
						st_d = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (cnt_q == 4'h0) begin
					st_d = lo_mode ? ST_READY : ST_DONE;
				end
			end
			ST_READY: begin
				if (!fb_q || !s_final_ready_in) begin
					st_d = ST_IDLE;
				end
			end
			ST_BUS_BACKOFF_OUT, ST_BUSY: begin
				if (cnt_q == 4'h0) begin
					st_d = ST_IDLE;
				end
			end
			ST_DONE: begin
				if (!strb) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q      <= ST_IDLE;
			cnt_q     <= 4'h0;
			cyc_mem_q <= 1'b0;
			cyc_zw_q  <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			if (st_q == ST_IDLE) begin
				cyc_mem_q <= is_mem;
				cyc_zw_q  <= zw_hit;
			end
			if (st_d != st_q) begin
				case (st_d)
					ST_WAIT: cnt_q <= 4'(WAIT_CYC - 1);
					ST_BUS_BACKOFF_OUT: cnt_q <= 4'(BUS_BACKOFF_OUT_CYC - 1);
					ST_BUSY: cnt_q <= 4'(CAPT_CYC - 1);
					default: cnt_q <= 4'h0;
				endcase
			end else if (cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end

	// Shared pins change role with the bus mode.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			backoff_romsel_o   <= 1'b1;
			backoff_romsel_oe  <= 1'b0;
			local_ready_out_o  <= 1'b1;
			local_ready_out_oe <= 1'b0;
			busy_zero_wait_o   <= 1'b0;
			io_sel16_o         <= 1'b1;
			io_sel16_oe        <= 1'b0;
			irq_o              <= 1'b0;
		end else if (ce) begin
			backoff_romsel_oe <= !ch_mode;
			io_sel16_oe       <= at_mode;
			if (lo_mode) begin
				backoff_romsel_o   <= !(st_d == ST_BUS_BACKOFF_OUT);
				local_ready_out_o  <= !(st_d == ST_READY);
				local_ready_out_oe <= (st_d == ST_READY);
				busy_zero_wait_o   <= (st_d == ST_BUSY);
			end else begin
				backoff_romsel_o   <= !at_mode || (rom_dis_q
					? rom_ctl_q[ROM_SEL_BIT]
					: !(mem_en && la_q == ROM_WIDE_HI));
				local_ready_out_o  <= !(st_d == ST_WAIT);
				local_ready_out_oe <= 1'b1;
				busy_zero_wait_o   <= !(st_d == ST_DONE && zw_now);
			end
			io_sel16_o <= !(at_mode && st_d != ST_IDLE && !mem_now);
			irq_o      <= ch_mode ? !pend_q : pend_q;
		end
	end

	// Upper lines are latched on the strobe's falling edge.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			la_q        <= 7'h00;
			ale_prev_q  <= 1'b0;
			strb_prev_q <= 1'b1;
		end else if (ce) begin
			ale_prev_q  <= s_ads;
			strb_prev_q <= strb;
			if (at_mode && ale_prev_q && !s_ads) begin
				la_q <= s_addr[23:17];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stb_q                 <= 4'h0;
			bios_rom_enable_out_n <= 1'b1;
		end else if (ce) begin
			if (page_wr) begin
				stb_q <= 4'(STROBE_CYC);
			end else if (stb_q != 4'h0) begin
				stb_q <= stb_q - 4'h1;
			end
			bios_rom_enable_out_n <= !(stb_q != 4'h0 || rom_win);
		end
	end

	// Buffered writes retire at a fixed rate; a full buffer forces backoff.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wb_q    <= '0;
			drain_q <= 4'h0;
		end else if (ce) begin
			drain_q <= (drain_q == 4'(DRAIN_CYC - 1)) ? 4'h0
				: drain_q + 4'h1;
			if (st_q == ST_IDLE && st_d == ST_WAIT && lo_mode && is_mem
				&& is_wr) begin
				if (!(drain_q == 4'h0 && wb_q != '0)) begin
					wb_q <= wb_q + WBW'(1);
				end
			end else if (drain_q == 4'h0 && wb_q != '0) begin
				wb_q <= wb_q - WBW'(1);
			end
		end
	end

	// Processor reset pins the internal half-rate phase to a known edge.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lclk_prev_q <= 1'b0;
			phase_q     <= 1'b0;
		end else if (ce) begin
			lclk_prev_q <= s_lclk;
			if (lo_mode && s_prst) begin
				phase_q <= 1'b0;
			end else if (s_lclk && !lclk_prev_q) begin
				phase_q <= !phase_q;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rom_ctl_q <= ROM_CTL_RST;
			zw_q      <= ZW_RST;
			retr_q    <= RETRACE_RST;
			pend_q    <= 1'b0;
			reg_rdata <= 32'h0000_0000;
		end else if (ce) begin
			if (reg_wr && reg_addr == REG_ROM_CTL) begin
				rom_ctl_q <= reg_wdata & ROM_CTL_MASK;
			end
			if (reg_wr && reg_addr == REG_ZW_CTL) begin
				zw_q <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == REG_RETRACE) begin
				retr_q <= reg_wdata[7:0];
			end
			// A display-end event beats a clear in the same cycle.
			if (vert_display_end && retr_q[IRQ_EN_BIT]) begin
				pend_q <= 1'b1;
			end else if (irq_clr) begin
				pend_q <= 1'b0;
			end
			reg_rdata <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					REG_ROM_CTL: reg_rdata <= rom_ctl_q;
					REG_ZW_CTL:  reg_rdata <= {24'h000000, zw_q};
					REG_RETRACE: reg_rdata <= {24'h000000, retr_q};
					REG_STATUS:  reg_rdata <= {23'h000000, s_card_select_feedback,
						st_q != ST_IDLE, wb_full, phase_q, pend_q, fb_q,
						rom_dis_q, mode_q};
					default:     reg_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !ce);

	a_bus_backoff_out_on_full: assert property (lo_mode && st_q == ST_IDLE && start
		&& claim && !fwd && is_mem && is_wr && wb_full
		|=> !backoff_romsel_o [*4] ##1 backoff_romsel_o)
		else $error("backoff not held for full buffer");
	a_rom_wide_dec: assert property (at_mode && !rom_dis_q && mem_en
		&& la_q == ROM_WIDE_HI |=> !backoff_romsel_o)
		else $error("ROM select missed decode");
	a_rom_mirror: assert property (at_mode && rom_dis_q |=>
		backoff_romsel_o == $past(rom_ctl_q[ROM_SEL_BIT]))
		else $error("ROM select does not mirror bit");
	a_busy_capture: assert property (lo_mode && st_q == ST_IDLE
		&& start && fwd |=> busy_zero_wait_o [*2] ##1 !busy_zero_wait_o)
		else $error("busy not held for capture");
	a_ready_tristate: assert property (lo_mode && local_ready_out_oe
		|-> !local_ready_out_o)
		else $error("ready driven while inactive");
	a_chrdy_wait: assert property (!lo_mode && st_q == ST_IDLE
		&& st_d == ST_WAIT |=> !local_ready_out_o [*3] ##1 local_ready_out_o)
		else $error("channel ready wait wrong");
	a_ready_nofb: assert property (lo_mode && !fb_q
		&& st_q == ST_READY |=> !local_ready_out_oe)
		else $error("cycle not ended without feedback");
	a_ready_fb: assert property (lo_mode && fb_q && st_q == ST_READY
		&& s_final_ready_in |=> local_ready_out_oe)
		else $error("cycle ended before feedback");
	a_page_strobe: assert property (page_wr
		|=> ##1 !bios_rom_enable_out_n [*4])
		else $error("page map strobe too short");
	a_irq_gate: assert property (!retr_q[IRQ_EN_BIT] && !pend_q
		|=> !pend_q)
		else $error("interrupt set while disabled");
	a_irq_hold: assert property (pend_q && !irq_clr |=> pend_q)
		else $error("interrupt dropped without clear");

	c_local_ready: cover property (st_q == ST_READY ##1 st_q == ST_IDLE);
	c_backoff: cover property (st_q == ST_BUS_BACKOFF_OUT);
	c_irq_clear: cover property (pend_q ##1 !pend_q);
	c_zero_wait: cover property (!busy_zero_wait_o && !lo_mode);

endmodule : mbh_host_ctl

// file: sim/mbh_host.sv
// Behavioural host that runs local and AT bus cycles against the block.
`timescale 1ns/10ps
module mbh_host (
	input  wire logic        ref_clk,
	input  wire logic [1:0]  mode,
	input  wire logic        fb,
	input  wire logic        rdy_wire,
	input  wire logic        busy_zero_wait_o,
	input  wire logic        io_sel16_o,
	input  wire logic        io_sel16_oe,
	input  wire logic        bios_rom_enable_out_n,
	output logic      [23:0] host_addr,
	output logic             link_clk,
	output logic             cmd_strobe,
	output logic             reset_or_mem_en,
	output logic             final_ready_in,
	output logic             addr_strobe,
	output logic             card_select_feedback,
	output logic             rw_strobe,
	output logic             mio_strobe,
	output logic             dc_strobe
);
	int   rdy, busy, rom, sel, zws;
	int   fb_lag = 0;
	logic at;

	assign at = (mode == 2'h1);

	initial begin
		{host_addr, link_clk, card_select_feedback} = 26'h1;
		{addr_strobe, final_ready_in} = 2'h3;
		{cmd_strobe, reset_or_mem_en, rw_strobe, mio_strobe, dc_strobe} = 5'h00;
	end

	// The processor clock only exists on a local bus; elsewhere it is held.
	always #100 link_clk = (mode == 2'h0) ? ~link_clk : 1'b0;

	task automatic idle();
		addr_strobe     <= !at;
		cmd_strobe      <= at;
		rw_strobe       <= at;
		mio_strobe      <= at;
		dc_strobe       <= at;
		reset_or_mem_en <= at;
		final_ready_in  <= 1'b1;
	endtask : idle

	task automatic run(input logic [23:0] a, input logic mem, wr, aux);
		int n;
		{rdy, busy, rom, sel, zws} = '0;
		@(posedge ref_clk);
		host_addr       <= a;
		reset_or_mem_en <= aux;
		// Strobes wait for the address to pass the pin filter first.
		if (at) begin
			addr_strobe <= 1'b1;
			repeat (3) @(posedge ref_clk);
			addr_strobe <= 1'b0;
			repeat (2) @(posedge ref_clk);
			case ({mem, wr})
				2'b11: dc_strobe <= 1'b0;
				2'b10: mio_strobe <= 1'b0;
				2'b01: cmd_strobe <= 1'b0;
				default: rw_strobe <= 1'b0;
			endcase
		end else begin
			mio_strobe <= mem;
			rw_strobe  <= wr;
			repeat (3) @(posedge ref_clk);
			addr_strobe <= 1'b0;
		end
		for (n = 0; n < 30; n++) begin
			@(posedge ref_clk);
			rdy  += !rdy_wire;
			busy += busy_zero_wait_o;
			zws  += !busy_zero_wait_o;
			rom  += !bios_rom_enable_out_n;
			sel  += io_sel16_oe && !io_sel16_o;
			if (!at && fb && rdy > fb_lag) final_ready_in <= 1'b0;
			if (!at && (rdy > 0 && rdy_wire || busy > 0 && !busy_zero_wait_o))
				break;
			if (at && n == 15) break;
		end
		idle();
		repeat (8) @(posedge ref_clk);
	endtask : run

endmodule : mbh_host

// file: sim/tb_top.sv
// Self-checking bench: register port, local and AT cycles, interrupt.
`timescale 1ns/10ps
module tb_top
	import mbh_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_n;
	logic        ce;
	logic [1:0]  mode_strap;
	logic        rom_decode_disable_strap;
	logic        ready_feedback_strap;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        vert_display_end;
	logic [23:0] host_addr;
	logic        link_clk, cmd_strobe, reset_or_mem_en, final_ready_in;
	logic        addr_strobe, card_select_feedback, rw_strobe, mio_strobe;
	logic        dc_strobe, backoff_romsel_o, backoff_romsel_oe;
	logic        local_ready_out_o, local_ready_out_oe, busy_zero_wait_o;
	logic        io_sel16_o, io_sel16_oe, bios_rom_enable_out_n, irq_o;
	logic        rdy_wire, seen;
	logic        rd_d = 1'b0;
	logic [63:0] exp_q[$];
	logic [63:0] note;
	logic [31:0] r;
	int          err_total = 0;
	int          samples_checked = 0;

	always #12.5 ref_clk = ~ref_clk;

	// A released ready line is pulled high by the board.
	assign rdy_wire = local_ready_out_oe ? local_ready_out_o : 1'b1;

	mbh_host_ctl #(.WBUF_DEPTH(4)) u_mbh_host_ctl (
		.ref_clk, .rst_n, .ce, .mode_strap, .rom_decode_disable_strap,
		.ready_feedback_strap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .vert_display_end, .host_addr, .link_clk, .cmd_strobe,
		.reset_or_mem_en, .final_ready_in, .addr_strobe,
		.card_select_feedback, .rw_strobe, .mio_strobe, .dc_strobe,
		.backoff_romsel_o, .backoff_romsel_oe, .local_ready_out_o,
		.local_ready_out_oe, .busy_zero_wait_o, .io_sel16_o, .io_sel16_oe,
		.bios_rom_enable_out_n, .irq_o
	);

	mbh_host u_mbh_host (
		.ref_clk, .mode(mode_strap), .fb(ready_feedback_strap), .rdy_wire,
		.busy_zero_wait_o, .io_sel16_o, .io_sel16_oe, .bios_rom_enable_out_n,
		.host_addr, .link_clk, .cmd_strobe, .reset_or_mem_en, .final_ready_in,
		.addr_strobe, .card_select_feedback, .rw_strobe, .mio_strobe,
		.dc_strobe
	);

	task automatic check(string n, logic [31:0] got, logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask : check

	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		exp_q.push_back({m, e});
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic vde();
		@(posedge ref_clk);
		vert_display_end <= 1'b1;
		@(posedge ref_clk);
		vert_display_end <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : vde

	task automatic reset_dut(input logic [1:0] m, input logic dis, fb);
		@(posedge ref_clk);
		rst_n                    <= 1'b0;
		mode_strap               <= m;
		rom_decode_disable_strap <= dis;
		ready_feedback_strap     <= fb;
		repeat (6) @(posedge ref_clk);
		u_mbh_host.idle();
		rst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask : reset_dut

	// Read data stand only in the cycle after the strobe.
	always @(posedge ref_clk) begin
		if (rd_d) begin
			note = exp_q.pop_front();
			check("reg_rdata", reg_rdata & note[63:32], note[31:0]);
		end
		rd_d <= reg_rd;
	end

	initial begin
		#1000000;
		err_total++;
		end_of_test();
	end

	initial begin
		{rst_n, ce, mode_strap, rom_decode_disable_strap} = 5'h08;
		{ready_feedback_strap, reg_wr, reg_rd, vert_display_end} = 4'h0;
		reg_addr  = 4'h0;
		reg_wdata = 32'h0;
		void'($urandom(6));
		reset_dut(2'h0, 1'b0, 1'b0);
		rd(REG_ROM_CTL, 32'h0, '1);
		rd(REG_ZW_CTL, 32'h0, '1);
		rd(REG_RETRACE, 32'h0, '1);
		rd(REG_STATUS, 32'h0, 32'hf);
		rd(4'hf, 32'h0, '1);
		wr(REG_ROM_CTL, '1);
		rd(REG_ROM_CTL, ROM_CTL_MASK, '1);
		r = $urandom();
		wr(REG_RETRACE, r);
		rd(REG_RETRACE, r & 32'hff, '1);
		wr(REG_ROM_CTL, 32'h1);
		u_mbh_host.run(24'h0003c0, 1'b0, 1'b0, 1'b0);
		check("ready_cycles", u_mbh_host.rdy, 1);
		check("ready_oe_idle", local_ready_out_oe, 1'b0);
		u_mbh_host.run(24'h0c0000, 1'b1, 1'b0, 1'b0);
		check("rom_enable_on", u_mbh_host.rom > 0, 1);
		wr(REG_ROM_CTL, 32'h0);
		u_mbh_host.run(24'h0c0000, 1'b1, 1'b0, 1'b0);
		check("rom_enable_off", u_mbh_host.rom, 0);
		wr(REG_ROM_CTL, 32'h2);
		u_mbh_host.run(24'h0003c8, 1'b0, 1'b1, 1'b0);
		check("busy_cycles", u_mbh_host.busy, CAPT_CYC);
		check("busy_no_ready", u_mbh_host.rdy, 0);
		wr(REG_RETRACE, 32'h0);
		vde();
		check("irq_masked", irq_o, 1'b0);
		wr(REG_RETRACE, 32'h20);
		vde();
		check("irq_set", irq_o, 1'b1);
		rd(REG_STATUS, 32'h10, 32'h10);
		wr(REG_RETRACE, 32'h30);
		repeat (3) @(posedge ref_clk);
		check("irq_hold", irq_o, 1'b1);
		wr(REG_RETRACE, 32'h20);
		repeat (3) @(posedge ref_clk);
		check("irq_clear", irq_o, 1'b0);
		reset_dut(2'h0, 1'b0, 1'b1);
		rd(REG_STATUS, 32'h8, 32'hf);
		u_mbh_host.fb_lag = 3;
		u_mbh_host.run(24'h0003c0, 1'b0, 1'b0, 1'b0);
		check("ready_held", u_mbh_host.rdy > 3, 1);
		reset_dut(2'h1, 1'b1, 1'b0);
		rd(REG_STATUS, 32'h5, 32'hf);
		seen = backoff_romsel_o;
		wr(REG_ROM_CTL, 32'h0001_0000);
		repeat (3) @(posedge ref_clk);
		check("romsel_mirror", seen ^ backoff_romsel_o, 1);
		check("romsel_oe", backoff_romsel_oe, 1'b1);
		u_mbh_host.run(24'h0046e8, 1'b0, 1'b1, 1'b1);
		check("page_strobe", u_mbh_host.rom, STROBE_CYC);
		u_mbh_host.run(24'h0003c0, 1'b0, 1'b0, 1'b1);
		check("sel16_hit", u_mbh_host.sel > 0, 1);
		u_mbh_host.run(24'h000300, 1'b0, 1'b0, 1'b1);
		check("sel16_miss", u_mbh_host.sel, 0);
		u_mbh_host.run(24'h0a0000, 1'b1, 1'b0, 1'b0);
		check("mem_enable_off", u_mbh_host.rdy, 0);
		u_mbh_host.run(24'h0a0000, 1'b1, 1'b0, 1'b1);
		check("channel_wait", u_mbh_host.rdy, WAIT_CYC);
		check("zero_wait_off", u_mbh_host.zws, 0);
		wr(REG_ZW_CTL, 32'h40);
		u_mbh_host.run(24'h0a0000, 1'b1, 1'b0, 1'b1);
		check("zero_wait_on", u_mbh_host.zws > 0, 1);
		check("zero_wait_no_hold", u_mbh_host.rdy, 0);
		reset_dut(2'h1, 1'b0, 1'b0);
		u_mbh_host.run(24'h0c0000, 1'b1, 1'b0, 1'b1);
		check("romsel_decode", backoff_romsel_o, 1'b0);
		reset_dut(2'h2, 1'b0, 1'b0);
		rd(REG_STATUS, 32'h2, 32'hf);
		check("irq_ch_idle", irq_o, 1'b1);
		check("romsel_ch_oe", backoff_romsel_oe, 1'b0);
		wr(REG_RETRACE, 32'h20);
		// A frozen block must not take the display-end event.
		ce <= 1'b0;
		vde();
		ce <= 1'b1;
		check("irq_ce_frozen", irq_o, 1'b1);
		vde();
		check("irq_ch_set", irq_o, 1'b0);
		end_of_test();
	end

endmodule : tb_top
